// ===== pkg/hb_ctrl_pkg.sv
// constants for the half-bridge serial control block
package hb_ctrl_pkg;

    // frame and word layout
    localparam int          WORD_W          = 16;
    localparam int          SWITCH_COUNT    = 6;
    localparam logic [4:0]  FRAME_BITS      = 5'h10;

    // control word fields
    localparam int          CTL_CLEAR_POS   = 0;
    localparam int          CTL_SWITCH_LSB  = 1;
    localparam int          CTL_OCS_POS     = 13;
    localparam logic [15:0] CTL_RESET       = 16'h2000;

    // status word fields
    localparam int          STS_THERMAL_POS = 0;
    localparam int          STS_SWITCH_LSB  = 1;
    localparam int          STS_SHORT_POS   = 13;
    localparam int          STS_OPEN_POS    = 14;
    localparam int          STS_SUPPLY_POS  = 15;

endpackage

// ===== hw/pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // pin side
    input  wire logic pinIn,
    // filtered level and edges
    output logic      level_r,
    output logic      rise_r,
    output logic      fall_r
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_r <= RESET_LEVEL;
            stage2_r <= RESET_LEVEL;
            stage3_r <= RESET_LEVEL;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_r <= RESET_LEVEL;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
        end else begin
            rise_r <= (stage2_r == stage3_r) && stage3_r && !level_r;
            fall_r <= (stage2_r == stage3_r) && !stage3_r && level_r;
            if (stage2_r == stage3_r) begin
                level_r <= stage3_r;
            end
        end
    end

endmodule

`default_nettype wire

// ===== hw/half_bridge_serial_control.sv
// serial control and status logic of a triple half-bridge driver
`timescale 1ns/1ps
`default_nettype none

module half_bridge_serial_control
    import hb_ctrl_pkg::*;
#(
    parameter int SWITCHES = SWITCH_COUNT
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // serial link pins
    input  wire logic                selectPinN,
    input  wire logic                serialClkPin,
    input  wire logic                serialInPin,
    output logic                     serialOut,
    output logic                     serialOutEn,
    // mode pin
    input  wire logic                inhibitPin,
    // power stage diagnostics
    input  wire logic                thermalWarnIn,
    input  wire logic [SWITCHES-1:0] overTempIn,
    input  wire logic [SWITCHES-1:0] shortEventIn,
    input  wire logic                openLoadIn,
    input  wire logic                underVoltageIn,
    // power stage drives and mode
    output logic [SWITCHES-1:0]      switchOn,
    output logic                     standby
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic csLvl;
    logic csRise;
    logic csFall;
    logic sclkRise;
    logic sclkFall;
    logic sdiLvl;
    logic inhLvl;

    // select is held high (deselected) during reset through reset level
    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   (selectPinN),
        .level_r (csLvl),
        .rise_r  (csRise),
        .fall_r  (csFall)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   (serialClkPin),
        .level_r (),
        .rise_r  (sclkRise),
        .fall_r  (sclkFall)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sdi (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   (serialInPin),
        .level_r (sdiLvl),
        .rise_r  (),
        .fall_r  ()
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_inh (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   (inhibitPin),
        .level_r (inhLvl),
        .rise_r  (),
        .fall_r  ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [WORD_W-1:0]   shiftIn_r;
    logic [4:0]          bitCount_r;
    logic [WORD_W-1:0]   ctrl_r;
    logic [WORD_W-1:0]   shiftOut_r;
    logic                sdo_r;
    logic                sdoOe_r;
    logic [SWITCHES-1:0] switchOn_r;
    logic [SWITCHES-1:0] switchOn_nxt;
    logic [SWITCHES-1:0] trip_r;
    logic [SWITCHES-1:0] tripSet;
    logic                shortFlag_r;
    logic                openFlag_r;
    logic                supplyFail_r;
    logic                standby_r;
    logic                selected;
    logic                wordFull;
    logic                clearPulse;
    logic [WORD_W-1:0]   statusWord;

    assign selected   = !csLvl;
    assign wordFull   = (bitCount_r == FRAME_BITS);
    assign clearPulse = csRise && wordFull && inhLvl && shiftIn_r[CTL_CLEAR_POS];

    ////////////////////////////////////////////////////////////////////////////
    // receive shift register

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shiftIn_r  <= '0;
            bitCount_r <= '0;
        end else if (csFall) begin
            bitCount_r <= '0;
        end else if (selected && sclkFall) begin
            shiftIn_r <= {sdiLvl, shiftIn_r[WORD_W-1:1]};
            if (!wordFull) begin
                bitCount_r <= bitCount_r + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register, standby

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTL_RESET;
        end else if (!inhLvl) begin
            ctrl_r <= CTL_RESET;
        end else if (csRise && wordFull) begin
            ctrl_r <= shiftIn_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            standby_r <= 1'b1;
        end else begin
            standby_r <= !inhLvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switch drive and protection

    always_comb begin
        switchOn_nxt = '0;
        tripSet      = '0;
        for (int i = 0; i < SWITCHES; i++) begin
            tripSet[i] = ctrl_r[CTL_OCS_POS] && shortEventIn[i] && switchOn_r[i];
        end
        for (int b = 0; b < SWITCHES / 2; b++) begin
            if (!(ctrl_r[CTL_SWITCH_LSB + 2*b] && ctrl_r[CTL_SWITCH_LSB + 2*b + 1])) begin
                switchOn_nxt[2*b]   = ctrl_r[CTL_SWITCH_LSB + 2*b];
                switchOn_nxt[2*b+1] = ctrl_r[CTL_SWITCH_LSB + 2*b + 1];
            end
        end
        switchOn_nxt = switchOn_nxt & ~overTempIn & ~trip_r & ~tripSet;
        if (!inhLvl) begin
            switchOn_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            switchOn_r <= '0;
            trip_r     <= '0;
        end else begin
            switchOn_r <= switchOn_nxt;
            trip_r     <= (trip_r & ~{SWITCHES{clearPulse}}) | tripSet;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky diagnostic flags, set wins over clear

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shortFlag_r  <= 1'b0;
            openFlag_r   <= 1'b0;
            supplyFail_r <= 1'b0;
        end else begin
            shortFlag_r  <= (shortFlag_r && !clearPulse) || (|tripSet);
            openFlag_r   <= (openFlag_r && !clearPulse) || (openLoadIn && |switchOn_r);
            supplyFail_r <= (supplyFail_r && !clearPulse) || underVoltageIn;
        end
    end

    always_comb begin
        statusWord                  = '0;
        statusWord[STS_THERMAL_POS] = thermalWarnIn;
        statusWord[STS_SWITCH_LSB +: SWITCHES] = switchOn_r;
        statusWord[STS_SHORT_POS]   = shortFlag_r;
        statusWord[STS_OPEN_POS]    = openFlag_r;
        statusWord[STS_SUPPLY_POS]  = supplyFail_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit path; input bits follow the status for chaining

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shiftOut_r <= '0;
        end else if (csFall) begin
            shiftOut_r <= statusWord;
        end else if (selected && sclkFall) begin
            shiftOut_r <= {sdiLvl, shiftOut_r[WORD_W-1:1]};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sdo_r <= 1'b0;
        end else if (csFall) begin
            sdo_r <= statusWord[STS_THERMAL_POS];
        end else if (selected && sclkRise) begin
            sdo_r <= shiftOut_r[0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sdoOe_r <= 1'b0;
        end else if (csFall) begin
            sdoOe_r <= 1'b1;
        end else if (csRise) begin
            sdoOe_r <= 1'b0;
        end
    end

    assign serialOut   = sdo_r;
    assign serialOutEn = sdoOe_r;
    assign switchOn    = switchOn_r;
    assign standby     = standby_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_oe_on_select: assert property (csFall |=> sdoOe_r)
        else $error("output not enabled after select fall");
    chk_oe_off_release: assert property (csRise |=> !sdoOe_r ##1 !sdoOe_r || csFall)
        else $error("output still driven after select release");
    chk_ctrl_hold: assert property (inhLvl && !csRise |=> $stable(ctrl_r))
        else $error("control word changed outside select release");
    chk_ctrl_apply: assert property (csRise && wordFull && inhLvl |=> ctrl_r == $past(shiftIn_r))
        else $error("shifted word not applied on select release");
    chk_sample_fall: assert property (selected && sclkFall && !csFall
        |=> shiftIn_r[WORD_W-1] == $past(sdiLvl))
        else $error("serial input not sampled on clock fall");
    chk_idle_no_shift: assert property (csLvl |=> $stable(shiftIn_r))
        else $error("shift register moved while deselected");
    chk_no_shoot: assert property (
        !(switchOn_r[0] && switchOn_r[1]) && !(switchOn_r[2] && switchOn_r[3])
        && !(switchOn_r[4] && switchOn_r[5]))
        else $error("both switches of a half-bridge on");
    chk_standby_off: assert property (!inhLvl |=> switchOn_r == '0 && standby_r)
        else $error("switch on during standby");
    chk_sdo_stable: assert property (selected && !sclkRise && !csFall |=> $stable(sdo_r))
        else $error("serial output changed without clock rise");
    chk_first_bit: assert property (csFall |=> sdo_r == $past(thermalWarnIn))
        else $error("first status bit is not the thermal warning");
    chk_overtemp_off: assert property (|overTempIn |=> (switchOn_r & $past(overTempIn)) == '0)
        else $error("switch on despite overtemperature");
    chk_flag_clear: assert property (clearPulse && !underVoltageIn |=> !supplyFail_r)
        else $error("supply fail flag not cleared");

endmodule

`default_nettype wire

// ===== tb/hb_host_model.sv
// host-side link model that sends control frames and gathers status
`timescale 1ns/1ps
`default_nettype none

module hb_host_model (
    // clock
    input  wire logic clk,
    // link pins
    input  wire logic serialOut,
    input  wire logic serialOutEn,
    output logic      selectPinN,
    output logic      serialClkPin,
    output logic      serialInPin
);
    initial begin
        selectPinN   = 1'b1;
        serialClkPin = 1'b0;
        serialInPin  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // half link period of 10 clk gives a 160 ns link clock
    task automatic frame(input logic [15:0] tx, input int nBits,
                         output logic [15:0] rx, output logic enOk);
        rx   = 16'h0000;
        enOk = 1'b1;
        wait_clk(1);
        selectPinN = 1'b0;
        wait_clk(10);
        for (int i = 0; i < nBits; i++) begin
            serialClkPin = 1'b1;
            serialInPin  = tx[i];
            wait_clk(10);
            serialClkPin = 1'b0;
            // no pull on the shared line: undriven it reads inverted
            rx[i]        = serialOutEn ? serialOut : ~serialOut;
            enOk         = enOk & (serialOutEn === 1'b1);
            wait_clk(10);
        end
        // data pin has a pull-down once released
        serialInPin = 1'b0;
        selectPinN  = 1'b1;
        wait_clk(10);
    endtask
endmodule

`default_nettype wire

// ===== tb/tb_half_bridge_serial_control.sv
// self-checking bench for the half-bridge serial control block
`timescale 1ns/1ps
`default_nettype none

module tb_half_bridge_serial_control;
    import hb_ctrl_pkg::*;

    logic        clk;
    logic        rstn;
    logic        selectPinN;
    logic        serialClkPin;
    logic        serialInPin;
    logic        serialOut;
    logic        serialOutEn;
    logic        inhibitPin;
    logic        thermalWarnIn;
    logic [5:0]  overTempIn;
    logic [5:0]  shortEventIn;
    logic        openLoadIn;
    logic        underVoltageIn;
    logic [5:0]  switchOn;
    logic        standby;
    logic [15:0] rx;
    logic        enOk;
    int          badCount;
    int          checkCount;

    half_bridge_serial_control dut_u (
        .clk(clk), .rstn(rstn), .selectPinN(selectPinN), .serialClkPin(serialClkPin),
        .serialInPin(serialInPin), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .inhibitPin(inhibitPin), .thermalWarnIn(thermalWarnIn), .overTempIn(overTempIn),
        .shortEventIn(shortEventIn), .openLoadIn(openLoadIn),
        .underVoltageIn(underVoltageIn), .switchOn(switchOn), .standby(standby)
    );

    hb_host_model host_u (
        .clk(clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .selectPinN(selectPinN), .serialClkPin(serialClkPin), .serialInPin(serialInPin)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // drives mode and diagnostic inputs together, off the clock edge
    task automatic setPins(input logic inhibit_pin, input logic tw, input logic [5:0] ot,
                           input logic [5:0] sh, input logic ol, input logic uv);
        inhibitPin     = inhibit_pin;
        thermalWarnIn  = tw;
        overTempIn     = ot;
        shortEventIn   = sh;
        openLoadIn     = ol;
        underVoltageIn = uv;
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic frameChk(input logic [15:0] tx, input logic [15:0] expRx);
        host_u.frame(tx, 16, rx, enOk);
        check("status word", rx, expRx);
        check("out enable in frame", 16'(enOk), 16'h0001);
        check("out enable idle", 16'(serialOutEn), 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testWrite();
        setPins(1'b1, 1'b1, 6'h00, 6'h00, 1'b0, 1'b0);
        frameChk(16'h2032, 16'h0001);
        check("switches applied", 16'(switchOn), 16'h0019);
        setPins(1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        frameChk(16'h2016, 16'h0032);
        check("cross-conduction", 16'(switchOn), 16'h0008);
        $display("write test done");
    endtask

    task automatic testFlags();
        setPins(1'b1, 1'b0, 6'h00, 6'h08, 1'b1, 1'b1);
        host_u.wait_clk(3);
        setPins(1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(3);
        check("short trip", 16'(switchOn), 16'h0000);
        frameChk(16'h2011, 16'he000);
        check("latch cleared", 16'(switchOn), 16'h0008);
        frameChk(16'h2010, 16'h0010);
        host_u.frame(16'h2002, 8, rx, enOk);
        check("short frame", 16'(switchOn), 16'h0008);
        $display("flag test done");
    endtask

    task automatic testStandby();
        setPins(1'b0, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(8);
        check("standby on", 16'(standby), 16'h0001);
        check("standby off switches", 16'(switchOn), 16'h0000);
        setPins(1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(8);
        check("standby off", 16'(standby), 16'h0000);
        $display("standby test done");
    endtask

    task automatic testProtect();
        frameChk(16'h0008, 16'h0000);
        check("no shutdown set", 16'(switchOn), 16'h0004);
        setPins(1'b1, 1'b0, 6'h00, 6'h04, 1'b0, 1'b0);
        host_u.wait_clk(3);
        setPins(1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(3);
        check("no trip", 16'(switchOn), 16'h0004);
        setPins(1'b1, 1'b0, 6'h04, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(4);
        check("overtemp off", 16'(switchOn), 16'h0000);
        setPins(1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(4);
        check("overtemp back", 16'(switchOn), 16'h0004);
        frameChk(16'h0000, 16'h0008);
        $display("protect test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        badCount       = 0;
        checkCount     = 0;
        rstn           = 1'b0;
        setPins(1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b0);
        host_u.wait_clk(4);
        check("reset enable", 16'(serialOutEn), 16'h0000);
        rstn = 1'b1;
        host_u.wait_clk(8);
        check("reset switches", 16'(switchOn), 16'h0000);
        check("normal mode", 16'(standby), 16'h0000);
        testWrite();
        testFlags();
        testStandby();
        testProtect();
        endOfTest();
    end

    initial begin
        #100000;
        badCount++;
        $display("watchdog expired");
        endOfTest();
    end
endmodule

`default_nettype wire
